// >>> src/ccps_top.sv
// Operation
// - four wire slave port: select low-active, serial clock, data in, data out
// - every command is a 16 bit word, most significant bit first
// - top four command bits hold the register address, sixteen locations
// - bit under the address: one reads, zero writes
// - low ten bits carry data stored into the addressed register on write
// - a read command returns the register as a 10-bit word on data out
// - sixteen addresses decoded, the highest one reserved with no function
// - addresses eight to eleven return input peak levels, read only
// - 0-1 playback control, 2-7 output attenuation, 12-14 record control
// - each attenuation register is an independent 10-bit linear level
// - default: command latched on one extra clock after select rises
// - option: command latched on the clock carrying the last data bit
`include "ccps_defs.svh"

module ccps_top
   import ccps_pkg::*;
#(
   parameter int DATA_W = `CCPS_DATA_W
) (
   // system clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_SYS_RST,
   // serial control link
   input wire logic I_CTRL_SELECT_N,
   input wire logic I_CTRL_SERIAL_CLOCK,
   input wire logic I_CTRL_DATA_IN,
   output logic O_CTRL_DATA_OUT,
   output logic O_CTRL_DATA_OUT_OE,
   // latch mode strap
   input wire logic I_LATCH_ON_LAST_BIT,
   // input peak levels from the record path
   input wire logic [DATA_W-1:0] I_IN_PEAK_CH0,
   input wire logic [DATA_W-1:0] I_IN_PEAK_CH1,
   input wire logic [DATA_W-1:0] I_IN_PEAK_CH2,
   input wire logic [DATA_W-1:0] I_IN_PEAK_CH3,
   // playback control and attenuation
   output logic [DATA_W-1:0] O_PLAYBACK_CTRL_FIRST,
   output logic [DATA_W-1:0] O_PLAYBACK_CTRL_SECOND,
   output logic [DATA_W-1:0] O_OUT_ATTEN_CH0,
   output logic [DATA_W-1:0] O_OUT_ATTEN_CH1,
   output logic [DATA_W-1:0] O_OUT_ATTEN_CH2,
   output logic [DATA_W-1:0] O_OUT_ATTEN_CH3,
   output logic [DATA_W-1:0] O_OUT_ATTEN_CH4,
   output logic [DATA_W-1:0] O_OUT_ATTEN_CH5,
   // record control
   output logic [DATA_W-1:0] O_RECORD_CTRL_FIRST,
   output logic [DATA_W-1:0] O_RECORD_CTRL_SECOND,
   output logic [DATA_W-1:0] O_RECORD_CTRL_THIRD
);

   ////////////////////////////////////////////////////////////////////////////////
   // elaboration check: the word layout is fixed at ten data bits
   generate
      if (DATA_W != `CCPS_DATA_W) begin : g_bad_width
         $error("ccps_top: DATA_W must equal the command data field width");
      end
   endgenerate

   // layout checks: the command fields must tile the word exactly, or the
   // shift register, the field decode and the read slots would disagree
   generate
      if (`CCPS_ADDR_MSB != `CCPS_CMD_W - 1) begin : g_bad_addr_top
         $error("ccps_top: address field must start at the top bit");
      end

      if (`CCPS_ADDR_MSB - `CCPS_ADDR_LSB + 1 != `CCPS_ADDR_W) begin : g_bad_addr_w
         $error("ccps_top: address field width disagrees with its bounds");
      end

      // the access flag sits directly under the address
      if (`CCPS_RW_BIT != `CCPS_ADDR_LSB - 1) begin : g_bad_rw
         $error("ccps_top: read/write flag must sit just below the address");
      end

      if (`CCPS_DATA_MSB - `CCPS_DATA_LSB + 1 != `CCPS_DATA_W) begin : g_bad_data_w
         $error("ccps_top: data field width disagrees with its bounds");
      end

      // one register slot per address value, no more and no less
      if (`CCPS_NUM_REGS != (1 << `CCPS_ADDR_W)) begin : g_bad_regs
         $error("ccps_top: register count must cover every address");
      end

      // read bits go out in exactly the slots that carry the data field
      if (`CCPS_CNT_OUT_FIRST != `CCPS_CMD_W - `CCPS_DATA_W) begin : g_bad_slot
         $error("ccps_top: first read slot must match the data field");
      end

      // the read decision must be taken before the first read slot is driven
      if (`CCPS_CNT_DECIDE >= `CCPS_CNT_OUT_FIRST) begin : g_bad_decide
         $error("ccps_top: read decision comes too late in the frame");
      end

      // the full count reached after the last bit must equal the command length
      if (`CCPS_CNT_FULL != `CCPS_CMD_W) begin : g_bad_full
         $error("ccps_top: full count must equal the command length");
      end
   endgenerate

   // access class of each location
   function automatic ccps_acc_t acc_of(input ccps_addr_t a);
      ccps_acc_t r;
      r = CCPS_ACC_RW;
      case (1'b1)
         (a >= `CCPS_A_PEAK0) && (a <= `CCPS_A_PEAK3): r = CCPS_ACC_RO;
         (a == `CCPS_A_UNUSED): r = CCPS_ACC_RSVD;
         default: r = CCPS_ACC_RW;
      endcase
      return r;
   endfunction

   // reset value of each writable location
   function automatic ccps_data_t rst_of(input ccps_addr_t a);
      ccps_data_t r;
      r = `CCPS_RST_ZERO;
      case (1'b1)
         (a >= `CCPS_A_ATTEN0) && (a <= `CCPS_A_ATTEN5): r = `CCPS_RST_ATTEN;
         (a == `CCPS_A_REC_CTRL2): r = `CCPS_RST_REC_CTRL2;
         (a == `CCPS_A_PB_CTRL1) || (a == `CCPS_A_PB_CTRL2): r = `CCPS_RST_CTRL;
         default: r = `CCPS_RST_ZERO;
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // frame timing on the link, counted in serial rising edges with select low:
   //    rises 1 to 16 shift in the command, most significant bit first
   //    rise 6 decides whether this frame carries a pending read result
   //    the falls after rises 6 to 15 drive read bits 9 down to 0
   //    the host takes those bits on rises 7 to 16
   //    extra-clock mode latches on the first rise with select high after 16 bits
   //    last-bit mode latches on rise 16 itself and needs no further clock
   // the system side sees a latch through a toggle, two to three cycles later
   // limitation: a read result shows in a later frame, never in its own frame
   // limitation: the serial clock stops between frames, so nothing in this
   // domain moves then; every decision is therefore taken on a frame's own edges

   ////////////////////////////////////////////////////////////////////////////////
   // link domain, clocked by the host's serial clock
   logic [`CCPS_CNT_W-1:0] bit_cnt_ff;
   logic [`CCPS_CNT_W-1:0] nxt_bit_cnt;
   ccps_cmd_t shift_ff;
   ccps_cmd_t cmd_hold_ff;
   logic req_tgl_ff;
   logic opt_s1_ff;
   logic opt_s2_ff;
   logic ack_s1_ff;
   logic ack_s2_ff;
   logic ack_seen_ff;
   logic frame_rd_ff;
   logic dout_ff;
   logic oe_ff;
   // system-domain words read across the boundary
   ccps_data_t rdat_ff;
   logic ack_tgl_ff;

   // shift and latch decode
   wire sel_act = ~I_CTRL_SELECT_N;
   wire [`CCPS_CMD_W-1:0] shift_nxt = {shift_ff[`CCPS_CMD_W-2:0], I_CTRL_DATA_IN};
   wire last_bit_latch = sel_act & opt_s2_ff & (bit_cnt_ff == `CCPS_CNT_LAST);
   wire extra_clk_latch = ~sel_act & ~opt_s2_ff & (bit_cnt_ff == `CCPS_CNT_FULL);
   wire latch_cmd = last_bit_latch | extra_clk_latch;
   wire [`CCPS_CMD_W-1:0] latch_word = last_bit_latch ? shift_nxt : shift_ff;
   wire rd_avail = ack_s2_ff ^ ack_seen_ff;
   // the ready synchroniser only moves on serial edges, so the decision waits
   // until a few edges of this frame have carried a result across
   wire rd_decide = sel_act & (bit_cnt_ff == `CCPS_CNT_DECIDE);

   // a frame that ended without its extra clock leaves the count at sixteen;
   // the next rise with select low then starts a new frame, so the stale word
   // can never be latched later by somebody else's extra clock
   // trade-off: a seventeenth bit inside one frame also restarts the count
   assign nxt_bit_cnt = !sel_act ? `CCPS_CNT_ZERO :
                        (bit_cnt_ff == `CCPS_CNT_FULL) ? `CCPS_CNT_ONE :
                        bit_cnt_ff + `CCPS_CNT_ONE;

   // rising-edge capture of command bits
   always_ff @(posedge I_CTRL_SERIAL_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         bit_cnt_ff <= `CCPS_CNT_ZERO;
         shift_ff <= '0;
      end else begin
         bit_cnt_ff <= nxt_bit_cnt;
         if (sel_act) begin
            shift_ff <= shift_nxt;
         end
      end
   end

   // hold the word and flag it; it stays put while the system side reads it
   always_ff @(posedge I_CTRL_SERIAL_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         cmd_hold_ff <= '0;
         req_tgl_ff <= 1'b0;
      end else if (latch_cmd) begin
         cmd_hold_ff <= latch_word;
         req_tgl_ff <= ~req_tgl_ff;
      end
   end

   // strap and read-ready synchronisers; they only advance while the clock runs,
   // so a strap change needs two serial edges before it takes effect
   always_ff @(posedge I_CTRL_SERIAL_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         opt_s1_ff <= 1'b0;
         opt_s2_ff <= 1'b0;
         ack_s1_ff <= 1'b0;
         ack_s2_ff <= 1'b0;
      end else begin
         opt_s1_ff <= I_LATCH_ON_LAST_BIT;
         opt_s2_ff <= opt_s1_ff;
         ack_s1_ff <= ack_tgl_ff;
         ack_s2_ff <= ack_s1_ff;
      end
   end

   // decide early in the frame whether it carries read data; the result is
   // marked as taken only when the frame that showed it is latched
   always_ff @(posedge I_CTRL_SERIAL_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         frame_rd_ff <= 1'b0;
         ack_seen_ff <= 1'b0;
      end else begin
         if (rd_decide) begin
            frame_rd_ff <= rd_avail;
         end
         if (latch_cmd && frame_rd_ff) begin
            ack_seen_ff <= ~ack_seen_ff;
         end
      end
   end

   // read data goes out in the ten data-field slots of the frame
   wire out_win = sel_act & frame_rd_ff & (bit_cnt_ff >= `CCPS_CNT_OUT_FIRST) &
                  (bit_cnt_ff <= `CCPS_CNT_LAST);
   wire [`CCPS_CNT_W-1:0] out_pos = `CCPS_CNT_LAST - bit_cnt_ff;

   // falling-edge drive so the host samples a settled bit
   always_ff @(negedge I_CTRL_SERIAL_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         dout_ff <= 1'b0;
         oe_ff <= 1'b0;
      end else begin
         oe_ff <= out_win;
         dout_ff <= out_win ? rdat_ff[out_pos[`CCPS_ADDR_W-1:0]] : 1'b0;
      end
   end

   // release the line as soon as select rises, even with the clock stopped
   assign O_CTRL_DATA_OUT = dout_ff;
   assign O_CTRL_DATA_OUT_OE = oe_ff & sel_act;

   ////////////////////////////////////////////////////////////////////////////////
   // system domain: command execution and register file
   logic req_s1_ff;
   logic req_s2_ff;
   logic req_s3_ff;
   ccps_data_t reg_view [`CCPS_NUM_REGS];
   ccps_data_t peak_in [`CCPS_NUM_PEAK];

   // toggle crossing; the held word is stable for many system cycles
   // because the serial clock is slow enough
   // the third stage only forms the edge, so the word is read at least two
   // system cycles after the toggle left the link side
   // hazard: a serial clock far above its limit could replace the held word
   // before it is read; nothing here detects that
   always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         req_s1_ff <= 1'b0;
         req_s2_ff <= 1'b0;
         req_s3_ff <= 1'b0;
      end else begin
         req_s1_ff <= req_tgl_ff;
         req_s2_ff <= req_s1_ff;
         req_s3_ff <= req_s2_ff;
      end
   end

   // command field decode
   wire cmd_evt = req_s2_ff ^ req_s3_ff;
   wire [`CCPS_ADDR_W-1:0] cmd_addr = cmd_hold_ff[`CCPS_ADDR_MSB:`CCPS_ADDR_LSB];
   wire cmd_is_rd = (cmd_hold_ff[`CCPS_RW_BIT] == `CCPS_RW_READ);
   wire [`CCPS_DATA_W-1:0] cmd_data = cmd_hold_ff[`CCPS_DATA_MSB:`CCPS_DATA_LSB];
   // the reserved bit is ignored whatever the host sends
   // writes to read-only and reserved slots fall through: those slots hold
   // no flip-flops, so no write strobe is ever formed for them

   assign peak_in[0] = I_IN_PEAK_CH0;
   assign peak_in[1] = I_IN_PEAK_CH1;
   assign peak_in[2] = I_IN_PEAK_CH2;
   assign peak_in[3] = I_IN_PEAK_CH3;

   // one slot per address; only writable slots hold flip-flops
   generate
      for (genvar i = 0; i < `CCPS_NUM_REGS; i++) begin : g_reg
         localparam ccps_addr_t A = ccps_addr_t'(i);
         if (acc_of(A) == CCPS_ACC_RW) begin : g_rw
            ccps_data_t val_ff;
            wire wr_hit = cmd_evt & ~cmd_is_rd & (cmd_addr == A);
            always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
               if (I_SYS_RST) begin
                  val_ff <= rst_of(A);
               end else if (wr_hit) begin
                  val_ff <= cmd_data;
               end
            end
            assign reg_view[i] = val_ff;
         end else if (acc_of(A) == CCPS_ACC_RO) begin : g_ro
            assign reg_view[i] = peak_in[i - `CCPS_A_PEAK0];
         end else begin : g_rsvd
            assign reg_view[i] = `CCPS_RST_ZERO;
         end
      end
   endgenerate

   // read response: capture and flag the link side in one cycle
   // the data and the toggle move in the same cycle, and the link side looks
   // at the toggle only after two of its own edges, so the data is settled
   // peak slots are sampled live here, at capture time, not at command time
   always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         rdat_ff <= `CCPS_RST_ZERO;
         ack_tgl_ff <= 1'b0;
      end else if (cmd_evt && cmd_is_rd) begin
         rdat_ff <= reg_view[cmd_addr];
         ack_tgl_ff <= ~ack_tgl_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // control outputs straight from the register flip-flops
   // playback control pair
   assign O_PLAYBACK_CTRL_FIRST = reg_view[`CCPS_A_PB_CTRL1];
   assign O_PLAYBACK_CTRL_SECOND = reg_view[`CCPS_A_PB_CTRL2];
   // each attenuator is a full 10-bit linear level, independent per channel
   assign O_OUT_ATTEN_CH0 = reg_view[`CCPS_A_ATTEN0];
   assign O_OUT_ATTEN_CH1 = reg_view[`CCPS_A_ATTEN0 + 4'h1];
   assign O_OUT_ATTEN_CH2 = reg_view[`CCPS_A_ATTEN0 + 4'h2];
   assign O_OUT_ATTEN_CH3 = reg_view[`CCPS_A_ATTEN0 + 4'h3];
   assign O_OUT_ATTEN_CH4 = reg_view[`CCPS_A_ATTEN0 + 4'h4];
   assign O_OUT_ATTEN_CH5 = reg_view[`CCPS_A_ATTEN5];
   // record control triple; the second one starts from its own reset value
   assign O_RECORD_CTRL_FIRST = reg_view[`CCPS_A_REC_CTRL1];
   assign O_RECORD_CTRL_SECOND = reg_view[`CCPS_A_REC_CTRL2];
   assign O_RECORD_CTRL_THIRD = reg_view[`CCPS_A_REC_CTRL3];

endmodule

// >>> src/ccps_defs.svh
`ifndef CCPS_DEFS_SVH
`define CCPS_DEFS_SVH

// command word layout
`define CCPS_CMD_W 16
`define CCPS_ADDR_W 4
`define CCPS_DATA_W 10
`define CCPS_ADDR_MSB 15
`define CCPS_ADDR_LSB 12
`define CCPS_RW_BIT 11
`define CCPS_RSVD_BIT 10
`define CCPS_DATA_MSB 9
`define CCPS_DATA_LSB 0
`define CCPS_RW_READ 1'b1
`define CCPS_NUM_REGS 16
`define CCPS_NUM_PEAK 4

// serial bit counts
`define CCPS_CNT_W 5
`define CCPS_CNT_ZERO 5'h00
`define CCPS_CNT_ONE 5'h01
`define CCPS_CNT_LAST 5'h0f
`define CCPS_CNT_FULL 5'h10
`define CCPS_CNT_OUT_FIRST 5'h06
`define CCPS_CNT_DECIDE 5'h05

// register addresses
`define CCPS_A_PB_CTRL1 4'h0
`define CCPS_A_PB_CTRL2 4'h1
`define CCPS_A_ATTEN0 4'h2
`define CCPS_A_ATTEN5 4'h7
`define CCPS_A_PEAK0 4'h8
`define CCPS_A_PEAK3 4'hb
`define CCPS_A_REC_CTRL1 4'hc
`define CCPS_A_REC_CTRL2 4'hd
`define CCPS_A_REC_CTRL3 4'he
`define CCPS_A_UNUSED 4'hf

// reset values
`define CCPS_RST_CTRL 10'h000
`define CCPS_RST_ATTEN 10'h3ff
`define CCPS_RST_REC_CTRL2 10'h380
`define CCPS_RST_ZERO 10'h000

`endif

// >>> src/ccps_pkg.sv
`include "ccps_defs.svh"

package ccps_pkg;
   typedef logic [`CCPS_ADDR_W-1:0] ccps_addr_t;
   typedef logic [`CCPS_DATA_W-1:0] ccps_data_t;
   typedef logic [`CCPS_CMD_W-1:0] ccps_cmd_t;
   typedef logic [`CCPS_CNT_W-1:0] ccps_cnt_t;
   // access class of a register location
   typedef enum logic [2:0] {
      CCPS_ACC_RW = 3'b001,
      CCPS_ACC_RO = 3'b010,
      CCPS_ACC_RSVD = 3'b100
   } ccps_acc_t;
endpackage

// >>> dv/ccps_monitor.sv
module ccps_monitor
   import ccps_pkg::*;
#(
   parameter int DATA_W = 10
) (
   // clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_SYS_RST,
   // serial link
   input wire logic I_CTRL_SELECT_N,
   input wire logic I_CTRL_SERIAL_CLOCK,
   input wire logic O_CTRL_DATA_OUT,
   input wire logic O_CTRL_DATA_OUT_OE,
   // register outputs
   input wire logic [DATA_W-1:0] O_PLAYBACK_CTRL_FIRST,
   input wire logic [DATA_W-1:0] O_OUT_ATTEN_CH0,
   input wire logic [DATA_W-1:0] O_RECORD_CTRL_SECOND
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sclk_q_ff;
   logic [3:0] quiet_ff;
   logic [3:0] nxt_quiet;
   logic [4:0] rise_ff;
   logic [4:0] nxt_rise;
   ////////////////
   // link clock seen from the system clock; only valid because the link is slow
   assign nxt_quiet = (I_CTRL_SERIAL_CLOCK != sclk_q_ff) ? 4'h0 :
                      quiet_ff + {3'h0, quiet_ff != 4'hf};
   assign nxt_rise = I_CTRL_SELECT_N ? 5'h00 : rise_ff + {4'h0, I_CTRL_SERIAL_CLOCK & ~sclk_q_ff};
   // edge history
   always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         sclk_q_ff <= 1'b0;
         quiet_ff <= 4'h0;
         rise_ff <= 5'h00;
      end else begin
         sclk_q_ff <= I_CTRL_SERIAL_CLOCK;
         quiet_ff <= nxt_quiet;
         rise_ff <= nxt_rise;
      end
   end
   ////////////////
   // all checks in the system domain
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (I_SYS_RST);
   a_reset_values: assert property ($fell(I_SYS_RST) |-> O_OUT_ATTEN_CH0 == 10'h3ff &&
      O_RECORD_CTRL_SECOND == 10'h380 && O_PLAYBACK_CTRL_FIRST == 10'h000) else $error("bad reset");
   a_oe_needs_select: assert property (O_CTRL_DATA_OUT_OE |-> !I_CTRL_SELECT_N)
      else $error("drive unselected");
   a_oe_after_six: assert property ($rose(O_CTRL_DATA_OUT_OE) |-> rise_ff == 5'h06)
      else $error("drive start slot");
   a_oe_on_fall: assert property ($rose(O_CTRL_DATA_OUT_OE) |-> !I_CTRL_SERIAL_CLOCK)
      else $error("drive start edge");
   a_out_on_fall: assert property ($changed(O_CTRL_DATA_OUT) && !I_CTRL_SELECT_N
      |-> !I_CTRL_SERIAL_CLOCK) else $error("data edge");
   a_playback_quiet: assert property ($changed(O_PLAYBACK_CTRL_FIRST) |-> quiet_ff < 4'h8)
      else $error("playback change");
   a_atten_quiet: assert property ($changed(O_OUT_ATTEN_CH0) |-> quiet_ff < 4'h8)
      else $error("atten change");
   a_record_quiet: assert property ($changed(O_RECORD_CTRL_SECOND) |-> quiet_ff < 4'h8)
      else $error("record change");
endmodule

// >>> dv/ccps_host.sv
module ccps_host
   import ccps_pkg::*;
(
   // serial link, host side
   output logic o_select_n,
   output logic o_sclk,
   output logic o_din,
   input wire logic i_dout
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle: clock stands low between frames
   initial begin
      o_select_n = 1'b1;
      o_sclk = 1'b0;
      o_din = 1'b1;
   end
   // one frame; 30 ns period keeps the link under its limit
   task automatic xfer(input ccps_cmd_t cmd, input int nbits, input logic extra,
                       output ccps_data_t rd);
      ccps_cmd_t w;
      w = cmd;
      w[10] = 1'b0;
      rd = '0;
      #2.5; // keeps every host edge off the system clock edges
      o_select_n = 1'b0;
      for (int i = 15; i > 15 - nbits; i--) begin
         o_din = w[i];
         #15 o_sclk = 1'b1;
         if (i <= 9) rd[i] = i_dout;
         #15 o_sclk = 1'b0;
      end
      o_select_n = 1'b1;
      o_din = ~o_din; // released line must not keep its level
      if (extra) begin
         #15 o_sclk = 1'b1;
         #15 o_sclk = 1'b0;
      end
      #197.5;
   endtask
endmodule

// >>> dv/test_codec_control_port_slave.sv
module test_codec_control_port_slave
   import ccps_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {ccps_addr_t a; ccps_data_t d; ccps_data_t e; logic rw;} ccps_row_t;
   logic clk, rst, sel_n, sclk, din, dout, dout_oe, mode;
   ccps_data_t peak [4];
   ccps_data_t regv [16];
   int fail_count = 0;
   int tests_run = 0;
   // write, then a read frame, with the result read back through the frame after it
   ccps_row_t rows [16] = '{
      '{4'h2, 10'h155, 10'h155, 1'b1}, '{4'h3, 10'h001, 10'h001, 1'b1},
      '{4'h4, 10'h200, 10'h200, 1'b1}, '{4'h5, 10'h3fe, 10'h3fe, 1'b1},
      '{4'h6, 10'h0ab, 10'h0ab, 1'b1}, '{4'h7, 10'h000, 10'h000, 1'b1},
      '{4'h0, 10'h2aa, 10'h2aa, 1'b1}, '{4'h1, 10'h155, 10'h155, 1'b1},
      '{4'hc, 10'h3ff, 10'h3ff, 1'b1}, '{4'hd, 10'h000, 10'h000, 1'b1},
      '{4'he, 10'h123, 10'h123, 1'b1}, '{4'h8, 10'h3ff, 10'h0c5, 1'b0},
      '{4'h9, 10'h3ff, 10'h1a6, 1'b0}, '{4'ha, 10'h3ff, 10'h2e7, 1'b0},
      '{4'hb, 10'h3ff, 10'h318, 1'b0}, '{4'hf, 10'h3ff, 10'h000, 1'b0}};
   ////////////////
   ccps_top #(.DATA_W(10)) i_ccps_top (
      .I_CLK_SYS(clk), .I_SYS_RST(rst), .I_CTRL_SELECT_N(sel_n), .I_CTRL_SERIAL_CLOCK(sclk),
      .I_CTRL_DATA_IN(din), .O_CTRL_DATA_OUT(dout), .O_CTRL_DATA_OUT_OE(dout_oe),
      .I_LATCH_ON_LAST_BIT(mode), .I_IN_PEAK_CH0(peak[0]), .I_IN_PEAK_CH1(peak[1]),
      .I_IN_PEAK_CH2(peak[2]), .I_IN_PEAK_CH3(peak[3]),
      .O_PLAYBACK_CTRL_FIRST(regv[0]), .O_PLAYBACK_CTRL_SECOND(regv[1]),
      .O_OUT_ATTEN_CH0(regv[2]), .O_OUT_ATTEN_CH1(regv[3]), .O_OUT_ATTEN_CH2(regv[4]),
      .O_OUT_ATTEN_CH3(regv[5]), .O_OUT_ATTEN_CH4(regv[6]), .O_OUT_ATTEN_CH5(regv[7]),
      .O_RECORD_CTRL_FIRST(regv[12]), .O_RECORD_CTRL_SECOND(regv[13]),
      .O_RECORD_CTRL_THIRD(regv[14]));
   ccps_host i_ccps_host (.o_select_n(sel_n), .o_sclk(sclk), .o_din(din), .i_dout(dout));
   // system clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   ////////////////
   task automatic check(input string what, input ccps_data_t exp, input ccps_data_t got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // reset, then every writable location shows its start value
   task automatic do_reset();
      ccps_data_t exp;
      @(posedge clk) rst <= 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      for (int a = 0; a < 15; a++) begin
         exp = (a > 1 && a < 8) ? 10'h3ff : ((a == 13) ? 10'h380 : 10'h000);
         if (a < 8 || a > 11) check("reset value", exp, regv[a]);
      end
   endtask
   ////////////////
   initial begin
      ccps_data_t rd;
      rst = 1'b1;
      mode = 1'b0;
      peak = '{10'h0c5, 10'h1a6, 10'h2e7, 10'h318};
      do_reset();
      foreach (rows[i]) begin
         i_ccps_host.xfer({rows[i].a, 2'b00, rows[i].d}, 16, 1'b1, rd);
         if (rows[i].rw) check("register", rows[i].d, regv[rows[i].a]);
         i_ccps_host.xfer({rows[i].a, 12'h800}, 16, 1'b1, rd);
         i_ccps_host.xfer(16'hf000, 16, 1'b1, rd);
         check("read data", rows[i].e, rd);
      end
      // default mode without the extra clock must not land the word
      i_ccps_host.xfer(16'h40f0, 16, 1'b0, rd);
      check("no extra clock", 10'h200, regv[4]);
      i_ccps_host.xfer(16'h2000, 12, 1'b1, rd);
      check("short frame", 10'h155, regv[2]);
      check("stale word", 10'h200, regv[4]);
      // mid-run reset, then latch on the last bit
      do_reset();
      @(posedge clk) mode <= 1'b1;
      i_ccps_host.xfer(16'hf000, 16, 1'b1, rd);
      i_ccps_host.xfer(16'h32c3, 16, 1'b0, rd);
      check("last bit latch", 10'h2c3, regv[3]);
      close_out();
   end
endmodule

bind ccps_top ccps_monitor #(.DATA_W(DATA_W)) i_ccps_monitor (
   .I_CLK_SYS(I_CLK_SYS), .I_SYS_RST(I_SYS_RST), .I_CTRL_SELECT_N(I_CTRL_SELECT_N),
   .I_CTRL_SERIAL_CLOCK(I_CTRL_SERIAL_CLOCK), .O_CTRL_DATA_OUT(O_CTRL_DATA_OUT),
   .O_CTRL_DATA_OUT_OE(O_CTRL_DATA_OUT_OE), .O_PLAYBACK_CTRL_FIRST(O_PLAYBACK_CTRL_FIRST),
   .O_OUT_ATTEN_CH0(O_OUT_ATTEN_CH0), .O_RECORD_CTRL_SECOND(O_RECORD_CTRL_SECOND));
